// ==== hdl/tcos_pkg.sv ====
// Constants for the transmit clock output selector.
// Assumes a single 250 MHz system clock and a plain register port.
`default_nettype none
package tcos_pkg;
  // ==========================================================
  // Register port
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [7:0]  CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  STAT_ADDR   = 8'h04;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  // ==========================================================
  // Control fields
  localparam int MODE_LSB = 0;
  localparam int MODE_W   = 3;
  localparam int PINEN_B  = 3;
  localparam int SEL_LSB  = 4;
  localparam int SEL_W    = 2;
  localparam int INV_B    = 6;
  // ==========================================================
  // Status fields
  localparam int FN_LSB   = 0;
  localparam int SOF_B    = 2;
  localparam int POHCK_B  = 3;
  // ==========================================================
  // Framing modes
  localparam logic [2:0] MODE_DS3      = 3'h0;
  localparam logic [2:0] MODE_E3       = 3'h1;
  localparam logic [2:0] MODE_DS3_PLCP = 3'h2;
  localparam logic [2:0] MODE_E3_PLCP  = 3'h3;
  localparam logic [2:0] MODE_INT_FRAC = 3'h4;
  localparam logic [2:0] MODE_EXT_FRAC = 3'h5;
  // ==========================================================
  // Pin function select
  localparam logic [1:0] SEL_TXCLK = 2'h0;
  localparam logic [1:0] SEL_GAP   = 2'h1;
  // ==========================================================
  // Active function codes shown in status
  localparam logic [1:0] FN_OFF    = 2'h0;
  localparam logic [1:0] FN_TXCLK  = 2'h1;
  localparam logic [1:0] FN_GAP    = 2'h2;
  localparam logic [1:0] FN_POH    = 2'h3;
  // ==========================================================
  // Overhead clock timing
  localparam int POH_DIV    = 8;
  localparam int POH_FRAME  = 12;
  typedef enum logic [1:0] {TCOS_OFF, TCOS_TX, TCOS_GAP, TCOS_POH} tcos_fn_e;
endpackage : tcos_pkg
`default_nettype wire

// ==== hdl/tcos_sync.sv ====
// Two-flop synchroniser for a group of level inputs.
// Assumes inputs are asynchronous to clk.
`default_nettype none
module tcos_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // ==========================================================
  // Synchroniser stages
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_out = sync_q;
endmodule // tcos_sync
`default_nettype wire

// ==== hdl/tcos_top.sv ====
// Transmit clock output selector: drives the shared clock pin and the PLCP overhead port.
// Assumes the framer transmit clock and overhead inputs arrive from outside clk.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`default_nettype none
// Functional notes
// - Plain clock equals framer transmit clock, ungated and undivided
// - Shared pin output may be inverted, whatever function it carries
// - Gapped clock enabled with pins on, selected, internal fractional or simple mode
// - Gapped clock is framer clock gated by payload marker or fractional enable
// - Overhead clock on pin in PLCP modes, pins on, plain clock not selected
// - On overhead clock fall: update frame start, sample overhead data and enable
// - Overhead enable selects which overhead bits the overhead data overwrites
module tcos_top
  import tcos_pkg::*;
#(
  parameter int DIV   = tcos_pkg::POH_DIV,
  parameter int FRAME = tcos_pkg::POH_FRAME
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [tcos_pkg::ADDR_W-1:0] addr,
  input  wire logic [tcos_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_stb,
  input  wire logic                       rd_stb,
  output logic      [tcos_pkg::DATA_W-1:0] rd_data,
  input  wire logic                       framer_tx_clock,
  input  wire logic                       transmit_payload_marker,
  input  wire logic                       fractional_overhead_enable_out,
  input  wire logic                       plcp_overhead_data_in,
  input  wire logic                       plcp_overhead_enable_in,
  output logic                            clock_pin,
  output logic                            plcp_overhead_frame_start,
  output logic                            overwrite_stb,
  output logic                            overwrite_data,
  output logic      [$clog2(FRAME)-1:0]   overwrite_index
);
  import tcos_pkg::*;
  localparam int CW = $clog2(DIV);
  localparam int FW = $clog2(FRAME);
  localparam logic [CW-1:0] HALF_M1  = CW'(DIV / 2 - 1);
  localparam logic [FW-1:0] FRAME_M1 = FW'(FRAME - 1);
  generate
    if (DIV < 2 || (DIV % 2) != 0 || FRAME < 2) begin : g_bad
      $error("tcos_top: DIV must be even and at least 2, FRAME at least 2");
    end
  endgenerate
  // ==========================================================
  // Synchronisers
  logic [4:0] sync_v;
  tcos_sync #(.W(5)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({framer_tx_clock, transmit_payload_marker, fractional_overhead_enable_out,
                plcp_overhead_data_in, plcp_overhead_enable_in}),
    .sync_out (sync_v)
  );
  logic txck_s, marker_s, frac_s, pohd_s, pohen_s;
  assign txck_s   = sync_v[4];
  assign marker_s = sync_v[3];
  assign frac_s   = sync_v[2];
  assign pohd_s   = sync_v[1];
  assign pohen_s  = sync_v[0];
  // ==========================================================
  // Register port
  logic [DATA_W-1:0] ctrl_q, ctrl_d, rd_q, rd_d;
  logic [2:0] mode;
  logic [1:0] sel;
  logic       pin_en, inv;
  tcos_fn_e   fn;
  logic       poh_ck_q, poh_ck_d;
  logic       sof_q, sof_d;
  function automatic logic [1:0] fn_code(input tcos_fn_e f);
    case (f)
      TCOS_TX:  fn_code = FN_TXCLK;
      TCOS_GAP: fn_code = FN_GAP;
      TCOS_POH: fn_code = FN_POH;
      default:  fn_code = FN_OFF;
    endcase
  endfunction
  assign mode   = ctrl_q[MODE_LSB +: MODE_W];
  assign sel    = ctrl_q[SEL_LSB +: SEL_W];
  assign pin_en = ctrl_q[PINEN_B];
  assign inv    = ctrl_q[INV_B];
  always_comb begin
    ctrl_d = ctrl_q;
    rd_d   = '0;
    if (wr_stb && addr == CTRL_ADDR) begin
      ctrl_d = '0;
      ctrl_d[INV_B:0] = wr_data[INV_B:0];
    end
    if (rd_stb) begin
      if (addr == CTRL_ADDR) begin
        rd_d = ctrl_q;
      end else if (addr == STAT_ADDR) begin
        rd_d[FN_LSB +: 2] = fn_code(fn);
        rd_d[SOF_B]       = sof_q;
        rd_d[POHCK_B]     = poh_ck_q;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      rd_q   <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      rd_q   <= rd_d;
    end
  end
  assign rd_data = rd_q;
  // ==========================================================
  // Function selection
  logic is_plcp, is_simple;
  assign is_plcp   = (mode == MODE_DS3_PLCP) || (mode == MODE_E3_PLCP);
  assign is_simple = (mode == MODE_DS3) || (mode == MODE_E3);
  always_comb begin
    if (sel == SEL_TXCLK && (mode == MODE_EXT_FRAC || pin_en)) begin
      fn = TCOS_TX;
    end else if (pin_en && sel == SEL_GAP && (mode == MODE_INT_FRAC || is_simple)) begin
      fn = TCOS_GAP;
    end else if (pin_en && is_plcp && sel != SEL_TXCLK) begin
      fn = TCOS_POH;
    end else begin
      fn = TCOS_OFF;
    end
  end
  // ==========================================================
  // Overhead clock divider and overhead port
  logic          txck_prev_q, txck_prev_d;
  logic [CW-1:0] div_q, div_d;
  logic [FW-1:0] idx_q, idx_d;
  logic          ow_stb_q, ow_stb_d, ow_dat_q, ow_dat_d;
  logic [FW-1:0] ow_idx_q, ow_idx_d;
  logic          poh_active, tx_rise, poh_fall;
  assign poh_active = pin_en && is_plcp;
  assign tx_rise    = txck_s && !txck_prev_q;
  assign poh_fall   = poh_active && tx_rise && div_q == HALF_M1 && poh_ck_q;
  always_comb begin
    txck_prev_d = txck_s;
    div_d       = div_q;
    poh_ck_d    = poh_ck_q;
    idx_d       = idx_q;
    sof_d       = sof_q;
    ow_stb_d    = 1'b0;
    ow_dat_d    = ow_dat_q;
    ow_idx_d    = ow_idx_q;
    if (!poh_active) begin
      div_d    = '0;
      poh_ck_d = 1'b0;
      idx_d    = FRAME_M1;
      sof_d    = 1'b0;
    end else if (tx_rise) begin
      if (div_q == HALF_M1) begin
        div_d    = '0;
        poh_ck_d = !poh_ck_q;
      end else begin
        div_d = div_q + CW'(1);
      end
      if (poh_fall) begin
        idx_d = (idx_q == FRAME_M1) ? '0 : idx_q + FW'(1);
        sof_d = (idx_q == FRAME_M1);
        if (pohen_s) begin
          ow_stb_d = 1'b1;
          ow_dat_d = pohd_s;
          ow_idx_d = idx_d;
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      txck_prev_q <= 1'b0;
      div_q       <= '0;
      poh_ck_q    <= 1'b0;
      idx_q       <= '0;
      sof_q       <= 1'b0;
      ow_stb_q    <= 1'b0;
      ow_dat_q    <= 1'b0;
      ow_idx_q    <= '0;
    end else begin
      txck_prev_q <= txck_prev_d;
      div_q       <= div_d;
      poh_ck_q    <= poh_ck_d;
      idx_q       <= idx_d;
      sof_q       <= sof_d;
      ow_stb_q    <= ow_stb_d;
      ow_dat_q    <= ow_dat_d;
      ow_idx_q    <= ow_idx_d;
    end
  end
  assign plcp_overhead_frame_start = sof_q;
  assign overwrite_stb             = ow_stb_q;
  assign overwrite_data            = ow_dat_q;
  assign overwrite_index           = ow_idx_q;
  // ==========================================================
  // Shared clock pin
  logic pin_q, pin_d, raw;
  always_comb begin
    case (fn)
      TCOS_TX:  raw = txck_s;
      TCOS_GAP: raw = txck_s & ((mode == MODE_INT_FRAC) ? frac_s : marker_s);
      TCOS_POH: raw = poh_ck_q;
      default:  raw = 1'b0;
    endcase
    pin_d = raw ^ inv;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end
  assign clock_pin = pin_q;
  // ==========================================================
  // Assertions
  txclk_follow_a: assert property (@(posedge clk) disable iff (rst)
    fn == TCOS_TX |=> clock_pin == ($past(txck_s) ^ $past(inv)))
    else $error("plain clock does not follow framer clock");
  ext_frac_en_a: assert property (@(posedge clk) disable iff (rst)
    (mode == MODE_EXT_FRAC && sel == SEL_TXCLK) |-> fn == TCOS_TX)
    else $error("plain clock not enabled in external fractional mode");
  gap_enable_a: assert property (@(posedge clk) disable iff (rst)
    (pin_en && sel == SEL_GAP && is_simple) |-> fn == TCOS_GAP)
    else $error("gapped clock not enabled in simple mode");
  gap_gate_a: assert property (@(posedge clk) disable iff (rst)
    (fn == TCOS_GAP && mode == MODE_INT_FRAC && !frac_s) |=> clock_pin == $past(inv))
    else $error("gapped clock not gated by fractional enable");
  poh_select_a: assert property (@(posedge clk) disable iff (rst)
    (pin_en && is_plcp && sel != SEL_TXCLK) |=> clock_pin == ($past(poh_ck_q) ^ $past(inv)))
    else $error("overhead clock not on pin");
  invert_pin_a: assert property (@(posedge clk) disable iff (rst)
    ($stable(fn) && $stable(raw) && $rose(inv)) |=> $changed(clock_pin))
    else $error("inversion has no effect on pin");
  sof_on_fall_a: assert property (@(posedge clk) disable iff (rst)
    (poh_active && $past(poh_active) && $changed(sof_q)) |-> $fell(poh_ck_q))
    else $error("frame start changed away from overhead clock fall");
  overwrite_fall_a: assert property (@(posedge clk) disable iff (rst)
    overwrite_stb |-> ($fell(poh_ck_q) && $past(pohen_s) && overwrite_data == $past(pohd_s)))
    else $error("overwrite not taken on overhead clock fall");
  idle_static_a: assert property (@(posedge clk) disable iff (rst)
    (fn == TCOS_OFF && $past(fn) == TCOS_OFF && $stable(inv)) |=> $stable(clock_pin))
    else $error("pin toggles while no function is enabled");
endmodule // tcos_top
`default_nettype wire

// ==== verif/tcos_poh_partner.sv ====
// Model of the external overhead logic on the PLCP overhead port.
// Assumes the overhead clock reaches it on the shared pin, not inverted.
`default_nettype none
module tcos_poh_partner (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic poh_clk,
  input  wire logic sof,
  output logic      ovh_data,
  output logic      ovh_en
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       prev;
  logic [3:0] cnt;
  // ==========================================================
  // Sample frame start, update data and enable on overhead clock rise
  // A sampled frame start restarts the data and enable pattern
  always @(posedge clk) begin
    prev <= poh_clk;
    if (rst) begin
      cnt      <= 4'h0;
      ovh_data <= 1'b0;
      ovh_en   <= 1'b0;
    end else if (poh_clk && !prev) begin
      cnt      <= sof ? 4'h1 : cnt + 4'h1;
      ovh_data <= cnt[1] & ~sof;
      ovh_en   <= ~cnt[0] | sof;
    end
  end
endmodule // tcos_poh_partner
`default_nettype wire

// ==== verif/tb_top.sv ====
// Testbench for the transmit clock output selector.
// Assumes the design and its package are compiled first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tcos_pkg::*;
  localparam int DV = 4;
  localparam int FR = 4;
  logic        clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0, rd_data, got;
  logic        framer = 1'b0, marker = 1'b0, frac_en = 1'b0, p_data, p_en;
  logic        clock_pin, sof, ow_stb, ow_data, prev_pin;
  logic [1:0]  ow_idx;
  logic [2:0]  fh = 3'h0, mh = 3'h0, eh = 3'h0;
  logic [31:0] tick = 32'h0, exp_v;
  logic [7:0]  ctab [7] = '{8'h08, 8'h48, 8'h05, 8'h18, 8'h5C, 8'h40, 8'h00};
  int          ktab [7] = '{1, 1, 1, 2, 3, 0, 0};
  int          num_errors = 0, checks = 0, falls, stbs;
  tcos_top #(.DIV(DV), .FRAME(FR)) uut (.clk(clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .framer_tx_clock(framer), .transmit_payload_marker(marker),
    .fractional_overhead_enable_out(frac_en), .plcp_overhead_data_in(p_data),
    .plcp_overhead_enable_in(p_en), .clock_pin(clock_pin),
    .plcp_overhead_frame_start(sof), .overwrite_stb(ow_stb),
    .overwrite_data(ow_data), .overwrite_index(ow_idx));
  tcos_poh_partner partner (.clk(clk), .rst(rst), .poh_clk(clock_pin), .sof(sof),
    .ovh_data(p_data), .ovh_en(p_en));
  always #2 clk = ~clk;
  // ==========================================================
  // Link side stimulus and its delayed copies
  always @(posedge clk) begin
    tick <= tick + 32'h1;
    if (tick % 10 == 9) framer <= ~framer;
    if (tick % 70 == 69) marker <= ~marker;
    if (tick % 50 == 49) frac_en <= ~frac_en;
    fh <= {fh[1:0], framer};
    mh <= {mh[1:0], marker};
    eh <= {eh[1:0], frac_en};
  end
  // ==========================================================
  // Access tasks and comparison
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rd_data;
  endtask
  function automatic logic [1:0] exp_fn(input logic [2:0] m, input logic p,
                                        input logic [1:0] s);
    if (s == SEL_TXCLK && (m == MODE_EXT_FRAC || p)) return FN_TXCLK;
    if (p && s == SEL_GAP && (m == MODE_INT_FRAC || m <= MODE_E3)) return FN_GAP;
    if (p && s != SEL_TXCLK && (m == MODE_DS3_PLCP || m == MODE_E3_PLCP)) return FN_POH;
    return FN_OFF;
  endfunction
  task automatic close_out;
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(CTRL_ADDR, got);
    cmp(got, CTRL_RESET);
    cmp({31'h0, clock_pin}, 32'h0);
    rd(8'h08, got);
    cmp(got, 32'h0);
    wr(CTRL_ADDR, 32'hFFFF_FFFF);
    rd(CTRL_ADDR, got);
    cmp(got, 32'h0000_007F);
    for (int i = 0; i < 64; i++) begin
      wr(CTRL_ADDR, {26'h0, i[5:0]});
      rd(STAT_ADDR, got);
      cmp({30'h0, got[1:0]}, {30'h0, exp_fn(i[2:0], i[3], i[5:4])});
    end
    for (int t = 0; t < 7; t++) begin
      wr(CTRL_ADDR, {24'h0, ctab[t]});
      repeat (8) @(posedge clk);
      repeat (200) begin
        @(negedge clk);
        exp_v = {31'h0, fh[2] & (ktab[t] == 2 ? mh[2] : ktab[t] == 3 ? eh[2] : 1'b1)};
        if (ktab[t] == 0) exp_v = 32'h0;
        cmp({31'h0, clock_pin}, exp_v ^ {31'h0, ctab[t][6]});
      end
    end
    wr(CTRL_ADDR, 32'h0000_002A);
    falls = 0;
    stbs = 0;
    prev_pin = clock_pin;
    repeat (2000) begin
      @(negedge clk);
      if (ow_stb === 1'b1) begin
        stbs++;
        cmp({30'h0, ow_idx}, falls % FR);
        cmp({31'h0, sof}, {31'h0, falls % FR == 0});
        cmp({31'h0, ow_data}, {31'h0, p_data});
        cmp({31'h0, p_en}, 32'h1);
      end
      if (prev_pin === 1'b1 && clock_pin === 1'b0) falls++;
      prev_pin = clock_pin;
    end
    cmp({31'h0, stbs > 4}, 32'h1);
    close_out();
  end
endmodule // tb_top
`default_nettype wire
